// *** hdl/pmrs_pkg.sv ***
// How it works
// - run mode keeps core, memory and peripheral clock enables all on
// - wait instruction stops core and memory clocks, peripherals keep running
// - wait returns to run on any interrupt, debug entry or reset
// - stop instruction keeps master clock but stops system clock generation unless a stop-disable bit is set
// - stop returns to run on stop-capable irq, low voltage, debug or reset
// - a set stop-disable bit keeps that peripheral clocked during stop
// - power-down stops every clock; only external or power-on reset recovers
// - wait and stop may be entered while in standby
// - standby runs the system clock at the reduced standby rate
// - watchdog tick is oscillator clock divided by 1024
// - peripherals run at system rate; high-speed option for pwm, timers, i2c
// - five reset sources: pin, power-on, software, watchdog timeout, lost reference
// - jtag reset comes from power-on reset only
// - extended power-on reset releases 64 oscillator ticks after raw release
// - clock generator reset releases 32 oscillator ticks after all sources
// - peripheral reset releases 32 system ticks after clock generator reset
// - core reset releases 32 system ticks after peripheral reset
// - power-on delay counters count oscillator ticks
// - software and watchdog reset logic held three oscillator ticks longer
// - peripheral and core resets release on the system clock edge tick
`default_nettype none
package pmrs_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int OSC_HZ = 8_000_000;
    localparam int OSC_STBY_HZ = 200_000;
    localparam int SYS_RUN_HZ = 20_000_000;
    localparam int SYS_STBY_HZ = 200_000;
    localparam logic [7:0] OSC_CYC = 8'(CLK_HZ / OSC_HZ);
    localparam logic [7:0] OSC_STBY_CYC = 8'(CLK_HZ / OSC_STBY_HZ);
    localparam logic [7:0] SYS_RUN_CYC = 8'(CLK_HZ / SYS_RUN_HZ);
    localparam logic [7:0] SYS_STBY_CYC = 8'(CLK_HZ / SYS_STBY_HZ);
    localparam logic [9:0] WDOG_DIV_LAST = 10'h3FF;
    localparam logic [6:0] POR_EXT_TICKS = 7'd64;
    localparam logic [6:0] CLKGEN_TICKS = 7'd32;
    localparam logic [6:0] PERIP_TICKS = 7'd32;
    localparam logic [6:0] CORE_TICKS = 7'd32;
    localparam logic [6:0] SWDOG_TICKS = 7'd3;
    localparam int N_PERIPH = 8;
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] CLKCFG_OFF = 12'h004;
    localparam logic [11:0] STOPDIS_OFF = 12'h008;
    localparam logic [11:0] STATUS_OFF = 12'h00C;
    localparam int CTRL_SWRST_BIT = 0;
    localparam int CTRL_HSEN_BIT = 1;
    localparam int CFG_SRC_BIT = 0;
    localparam int CFG_PLL_POWER_DOWN_BIT = 1;
    localparam int CFG_OSCSB_BIT = 2;
    localparam int CFG_LRSB_BIT = 3;
    localparam int CFG_OSCPD_BIT = 4;
    localparam logic [4:0] CLKCFG_RESET = 5'h00;
    localparam logic [7:0] STOPDIS_RESET = 8'h00;

    typedef enum logic [1:0]
    {
        MODE_RUN = 2'b00,
        MODE_WAIT = 2'b01,
        MODE_STOP = 2'b10
    } power_mode_t;

    typedef struct packed
    {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
endpackage
`default_nettype wire

// *** hdl/power_mode_reset_sequencer.sv ***
`default_nettype none
module power_mode_reset_sequencer (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ext_rst_b_in,
    input wire pmrs_pkg::apb_req_t apb_req_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic wait_instr_in,
    input wire logic stop_instr_in,
    input wire logic irq_in,
    input wire logic stop_irq_in,
    input wire logic low_voltage_irq_in,
    input wire logic debug_entry_in,
    input wire logic watchdog_timeout_reset_in,
    input wire logic watchdog_lost_reference_reset_in,
    output logic jtag_reset_out,
    output logic clock_gen_reset_out,
    output logic peripheral_reset_out,
    output logic core_reset_out,
    output logic swdog_reset_out,
    output logic master_clk_en_out,
    output logic core_mem_clk_en_out,
    output logic [pmrs_pkg::N_PERIPH-1:0] periph_clk_en_out,
    output logic hs_clk_en_out,
    output logic sys_tick_out,
    output logic osc_tick_out,
    output logic watchdog_tick_out
);
    import pmrs_pkg::*;

    function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off);
        reg_hit = (addr[11:2] == off[11:2]);
    endfunction

    logic por_s1_q, por_s2_q, ext_s1_q, ext_s2_q;
    logic ext_por_busy, swdog_busy;
    logic sw_req_q, wdog_req_q;
    logic [7:0] osc_cnt_q, sys_cnt_q;
    logic [9:0] wdog_cnt_q;
    logic [4:0] clkcfg_q;
    logic [7:0] stopdis_q;
    logic hs_en_q;
    power_mode_t mode_q, mode_d;
    logic [N_PERIPH-1:0] periph_en_d;
    wire wr_ctrl, wr_cfg, wr_sd;

    // pin and power-on resets assert asynchronously, release through two flops
    wire comb_async_b = rst_b_in & ext_rst_b_in;
    wire comb_hold = ext_por_busy | ~ext_s2_q | sw_req_q | wdog_req_q;

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            por_s1_q <= 1'b0;
            por_s2_q <= 1'b0;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            jtag_reset_out <= 1'b1;
        end
        else
        begin
            por_s1_q <= 1'b1;
            por_s2_q <= por_s1_q;
            ext_s1_q <= ext_rst_b_in;
            ext_s2_q <= ext_s1_q;
            jtag_reset_out <= ~por_s2_q;
        end
    end

    // configuration decode
    wire relax_src = clkcfg_q[CFG_SRC_BIT];
    wire pll_down = clkcfg_q[CFG_PLL_POWER_DOWN_BIT];
    wire osc_slow = clkcfg_q[CFG_OSCSB_BIT];
    wire lreg_sb = clkcfg_q[CFG_LRSB_BIT];
    wire standby = relax_src & pll_down & osc_slow & lreg_sb;
    wire power_down = standby & clkcfg_q[CFG_OSCPD_BIT];
    wire pll_sel = ~relax_src & ~pll_down;

    // oscillator tick: stops outright when the oscillator is powered down
    wire [7:0] osc_last = osc_slow ? OSC_STBY_CYC - 8'd1 : OSC_CYC - 8'd1;
    wire osc_wrap = (osc_cnt_q >= osc_last);
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            osc_cnt_q <= 8'h00;
            osc_tick_out <= 1'b0;
        end
        else
        begin
            osc_cnt_q <= (osc_wrap || power_down) ? 8'h00 : osc_cnt_q + 8'd1;
            osc_tick_out <= osc_wrap & ~power_down;
        end
    end

    // watchdog time base is independent of the system clock rate
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            wdog_cnt_q <= 10'h000;
            watchdog_tick_out <= 1'b0;
        end
        else
        begin
            if (osc_tick_out)
                wdog_cnt_q <= wdog_cnt_q + 10'd1;
            watchdog_tick_out <= osc_tick_out && (wdog_cnt_q == WDOG_DIV_LAST);
        end
    end

    // reset extenders; every stage before the system clock counts oscillator ticks
    reset_stretch #(.LIMIT(POR_EXT_TICKS)) u_por_ext (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .hold_in(~por_s2_q),
        .tick_in(osc_tick_out),
        .busy_out(ext_por_busy)
    );
    reset_stretch #(.LIMIT(SWDOG_TICKS)) u_swdog (
        .clk_in(clk_in),
        .rst_b_in(comb_async_b),
        .hold_in(comb_hold),
        .tick_in(osc_tick_out),
        .busy_out(swdog_busy)
    );
    reset_stretch #(.LIMIT(CLKGEN_TICKS)) u_clkgen (
        .clk_in(clk_in),
        .rst_b_in(comb_async_b),
        .hold_in(comb_hold),
        .tick_in(osc_tick_out),
        .busy_out(clock_gen_reset_out)
    );
    reset_stretch #(.LIMIT(PERIP_TICKS)) u_perip (
        .clk_in(clk_in),
        .rst_b_in(comb_async_b),
        .hold_in(clock_gen_reset_out | comb_hold),
        .tick_in(sys_tick_out),
        .busy_out(peripheral_reset_out)
    );
    reset_stretch #(.LIMIT(CORE_TICKS)) u_core (
        .clk_in(clk_in),
        .rst_b_in(comb_async_b),
        .hold_in(peripheral_reset_out | comb_hold),
        .tick_in(sys_tick_out),
        .busy_out(core_reset_out)
    );
    assign swdog_reset_out = swdog_busy;

    // synchronous reset requests; ignored in power-down where only pins recover
    always_ff @(posedge clk_in or negedge comb_async_b)
    begin
        if (!comb_async_b)
        begin
            sw_req_q <= 1'b0;
            wdog_req_q <= 1'b0;
        end
        else if (swdog_busy)
        begin
            sw_req_q <= 1'b0;
            wdog_req_q <= 1'b0;
        end
        else
        begin
            if (wr_ctrl && apb_req_in.pwdata[CTRL_SWRST_BIT] && !power_down)
                sw_req_q <= 1'b1;
            if ((watchdog_timeout_reset_in || watchdog_lost_reference_reset_in) && !power_down)
                wdog_req_q <= 1'b1;
        end
    end

    // system tick: reduced in standby, halted in stop unless a peripheral needs it
    wire sys_run = ~clock_gen_reset_out & ~power_down & ((mode_q != MODE_STOP) | (|stopdis_q));
    wire [7:0] sys_last = standby ? SYS_STBY_CYC - 8'd1 : SYS_RUN_CYC - 8'd1;
    wire sys_wrap = (sys_cnt_q >= sys_last);
    always_ff @(posedge clk_in or negedge comb_async_b)
    begin
        if (!comb_async_b)
        begin
            sys_cnt_q <= 8'h00;
            sys_tick_out <= 1'b0;
        end
        else
        begin
            sys_cnt_q <= (sys_wrap || !sys_run) ? 8'h00 : sys_cnt_q + 8'd1;
            sys_tick_out <= sys_wrap & sys_run;
        end
    end

    // power mode sequencing; standby is orthogonal so wait and stop nest inside it
    always_comb
    begin
        mode_d = mode_q;
        unique case (mode_q)
            MODE_RUN:
            begin
                if (wait_instr_in)
                    mode_d = MODE_WAIT;
                else if (stop_instr_in)
                    mode_d = MODE_STOP;
            end
            MODE_WAIT:
            begin
                if (irq_in || stop_irq_in || low_voltage_irq_in || debug_entry_in)
                    mode_d = MODE_RUN;
            end
            MODE_STOP:
            begin
                if (stop_irq_in || low_voltage_irq_in || debug_entry_in)
                    mode_d = MODE_RUN;
            end
            default:
                mode_d = MODE_RUN;
        endcase
    end

    // any reset drops the mode straight back to run
    always_ff @(posedge clk_in or negedge comb_async_b)
    begin
        if (!comb_async_b)
            mode_q <= MODE_RUN;
        else if (peripheral_reset_out)
            mode_q <= MODE_RUN;
        else
            mode_q <= mode_d;
    end

    // per-peripheral gating, stop-disable bits override stop
    generate
        for (genvar i = 0; i < N_PERIPH; i++)
        begin : g_periph
            assign periph_en_d[i] = ~power_down & ((mode_q != MODE_STOP) | stopdis_q[i]);
        end
    endgenerate

    // clock enables are registered so outputs never glitch
    always_ff @(posedge clk_in or negedge comb_async_b)
    begin
        if (!comb_async_b)
        begin
            master_clk_en_out <= 1'b1;
            core_mem_clk_en_out <= 1'b1;
            periph_clk_en_out <= '1;
            hs_clk_en_out <= 1'b0;
        end
        else
        begin
            master_clk_en_out <= ~power_down;
            core_mem_clk_en_out <= (mode_q == MODE_RUN) & ~power_down;
            periph_clk_en_out <= periph_en_d;
            hs_clk_en_out <= hs_en_q & pll_sel & ~standby & (mode_q != MODE_STOP);
        end
    end

    // apb slave: no wait states, unmapped addresses answer with pslverr
    wire setup = apb_req_in.psel & ~apb_req_in.penable;
    wire access = apb_req_in.psel & apb_req_in.penable & pready_out;
    wire hit_ctrl = reg_hit(apb_req_in.paddr, CTRL_OFF);
    wire hit_cfg = reg_hit(apb_req_in.paddr, CLKCFG_OFF);
    wire hit_sd = reg_hit(apb_req_in.paddr, STOPDIS_OFF);
    wire hit_stat = reg_hit(apb_req_in.paddr, STATUS_OFF);
    wire hit_any = hit_ctrl | hit_cfg | hit_sd | hit_stat;
    assign wr_ctrl = access & apb_req_in.pwrite & hit_ctrl;
    assign wr_cfg = access & apb_req_in.pwrite & hit_cfg;
    assign wr_sd = access & apb_req_in.pwrite & hit_sd;
    wire [31:0] status_w = {24'h000000, swdog_busy, core_reset_out, peripheral_reset_out,
                            clock_gen_reset_out, power_down, standby, mode_q};
    wire [31:0] rdata_w = hit_ctrl ? {30'h00000000, hs_en_q, 1'b0} :
                          hit_cfg ? {27'h0000000, clkcfg_q} :
                          hit_sd ? {24'h000000, stopdis_q} :
                          hit_stat ? status_w : 32'h00000000;

    always_ff @(posedge clk_in or negedge comb_async_b)
    begin
        if (!comb_async_b)
        begin
            pready_out <= 1'b0;
            prdata_out <= 32'h00000000;
            pslverr_out <= 1'b0;
        end
        else
        begin
            pready_out <= setup;
            prdata_out <= setup ? rdata_w : 32'h00000000;
            pslverr_out <= setup & ~hit_any;
        end
    end

    // software-owned controls; the entry and exit order of standby is software's job
    always_ff @(posedge clk_in or negedge comb_async_b)
    begin
        if (!comb_async_b)
        begin
            clkcfg_q <= CLKCFG_RESET;
            stopdis_q <= STOPDIS_RESET;
            hs_en_q <= 1'b0;
        end
        else
        begin
            if (wr_cfg)
                clkcfg_q <= apb_req_in.pwdata[4:0];
            if (wr_sd)
                stopdis_q <= apb_req_in.pwdata[7:0];
            if (wr_ctrl)
                hs_en_q <= apb_req_in.pwdata[CTRL_HSEN_BIT];
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!comb_async_b);

    chk_run_clocks_on: assert property ((mode_q == MODE_RUN && !power_down) |=>
        (core_mem_clk_en_out && (&periph_clk_en_out)))
        else $error("run mode lost a clock enable");
    chk_wait_gating: assert property ((mode_q == MODE_WAIT && !power_down) |=>
        (!core_mem_clk_en_out && (&periph_clk_en_out)))
        else $error("wait mode gating wrong");
    chk_wait_exit: assert property ((mode_q == MODE_WAIT && irq_in && !peripheral_reset_out)
        |=> mode_q == MODE_RUN)
        else $error("wait did not return to run");
    chk_stop_exit: assert property ((mode_q == MODE_STOP && low_voltage_irq_in)
        |=> mode_q == MODE_RUN)
        else $error("stop did not return to run");
    chk_stop_override: assert property ((mode_q == MODE_STOP && !power_down) |=>
        periph_clk_en_out == $past(stopdis_q))
        else $error("stop-disable override wrong");
    chk_powerdown_off: assert property (power_down |=>
        (!master_clk_en_out && periph_clk_en_out == '0 && !osc_tick_out))
        else $error("power-down left a clock running");
    chk_jtag_por_only: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (por_s2_q && !ext_s2_q) |=> !jtag_reset_out)
        else $error("jtag reset followed the pin reset");
    chk_por_extend: assert property ($rose(por_s2_q) |-> ext_por_busy[*8])
        else $error("power-on extension too short");
    chk_phase_order: assert property (clock_gen_reset_out |->
        (peripheral_reset_out && core_reset_out))
        else $error("reset phases out of order");
    chk_core_after_perip: assert property ($fell(peripheral_reset_out) |->
        core_reset_out[*8])
        else $error("core released too soon");
endmodule
`default_nettype wire

// *** hdl/reset_stretch.sv ***
`default_nettype none
module reset_stretch #(
    parameter logic [6:0] LIMIT = 7'd32
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic hold_in,
    input wire logic tick_in,
    output logic busy_out
);
    logic [6:0] cnt_q;

    // assertion is immediate, release waits LIMIT ticks after hold drops
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            busy_out <= 1'b1;
            cnt_q <= 7'h00;
        end
        else if (hold_in)
        begin
            busy_out <= 1'b1;
            cnt_q <= 7'h00;
        end
        else if (busy_out && tick_in)
        begin
            if (cnt_q == LIMIT - 7'd1)
                busy_out <= 1'b0;
            cnt_q <= cnt_q + 7'd1;
        end
    end
endmodule
`default_nettype wire

// *** sim/core_model.sv ***
`default_nettype none
module core_model (
    input wire logic clk_in,
    input wire logic core_reset_in,
    input wire logic [pmrs_pkg::N_PERIPH-1:0] periph_clk_en_in,
    input wire logic wait_req_in,
    input wire logic stop_req_in,
    input wire logic irq_req_in,
    output logic wait_instr_out,
    output logic stop_instr_out,
    output logic stop_irq_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // core runs no code in reset; an unclocked peripheral raises nothing
    always_ff @(posedge clk_in or posedge core_reset_in)
    begin
        if (core_reset_in)
        begin
            wait_instr_out <= 1'b0;
            stop_instr_out <= 1'b0;
            stop_irq_out <= 1'b0;
        end
        else
        begin
            wait_instr_out <= wait_req_in;
            stop_instr_out <= stop_req_in;
            stop_irq_out <= irq_req_in & periph_clk_en_in[0];
        end
    end
endmodule
`default_nettype wire

// *** sim/test_power_mode_reset_sequencer.sv ***
`default_nettype none
module test_power_mode_reset_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    import pmrs_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ext_rst_b = 1'b1;
    apb_req_t req = '0;
    logic wait_req = 1'b0, stop_req = 1'b0, irq_req = 1'b0, wdog_to = 1'b0, wdog_lor = 1'b0;
    logic [2:0] wake = 3'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, jtag_rst, cg_rst, per_rst, core_rst, sw_rst;
    logic mclk_en, cm_en, hs_en, sys_tick, osc_tick, wd_tick, wait_i, stop_i, stop_irq;
    logic [N_PERIPH-1:0] per_en;
    wire [2:0] ticks = {wd_tick, osc_tick, sys_tick};
    wire [2:0] rsts = {core_rst, per_rst, cg_rst};
    int bad_count = 0, checks_done = 0, cycles = 0;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    power_mode_reset_sequencer u_power_mode_reset_sequencer (.clk_in(clk), .rst_b_in(rst_b),
        .ext_rst_b_in(ext_rst_b), .apb_req_in(req), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .wait_instr_in(wait_i), .stop_instr_in(stop_i),
        .irq_in(wake[0]), .stop_irq_in(stop_irq), .low_voltage_irq_in(wake[1]),
        .debug_entry_in(wake[2]), .watchdog_timeout_reset_in(wdog_to),
        .watchdog_lost_reference_reset_in(wdog_lor), .jtag_reset_out(jtag_rst),
        .clock_gen_reset_out(cg_rst), .peripheral_reset_out(per_rst),
        .core_reset_out(core_rst), .swdog_reset_out(sw_rst), .master_clk_en_out(mclk_en),
        .core_mem_clk_en_out(cm_en), .periph_clk_en_out(per_en), .hs_clk_en_out(hs_en),
        .sys_tick_out(sys_tick), .osc_tick_out(osc_tick), .watchdog_tick_out(wd_tick));

    core_model u_core_model (.clk_in(clk), .core_reset_in(core_rst), .periph_clk_en_in(per_en),
        .wait_req_in(wait_req), .stop_req_in(stop_req), .irq_req_in(irq_req),
        .wait_instr_out(wait_i), .stop_instr_out(stop_i), .stop_irq_out(stop_irq));

    task automatic end_of_test();
        if (bad_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    // counts taken around async edges may slip up to two ticks either way
    task automatic near(input int n, input int w);
        check((n >= w - 2 && n <= w + 2) ? w : n, w);
    endtask

    // holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req <= '0;
    endtask

    task automatic period(input int sel, input int w);
        int n;
        n = 0;
        do @(posedge clk); while (ticks[sel] !== 1'b1);
        do
        begin
            @(posedge clk);
            n++;
        end while (ticks[sel] !== 1'b1);
        check(n, w);
    endtask

    task automatic seq(input int first);
        int n;
        for (int s = 0; s < 3; s++)
        begin
            n = 0;
            while (rsts[s] !== 1'b0)
            begin
                @(posedge clk);
                n += (s == 0) ? osc_tick : sys_tick;
            end
            near(n, (s == 0) ? first : 32);
        end
    endtask

    task automatic instr(input logic stop);
        @(posedge clk);
        stop_req <= stop;
        wait_req <= !stop;
        @(posedge clk);
        stop_req <= 1'b0;
        wait_req <= 1'b0;
        tick(4);
        #2;
    endtask

    // index 3 is a peripheral interrupt raised through the core model
    task automatic wake_ev(input int i);
        @(posedge clk);
        if (i == 3)
            irq_req <= 1'b1;
        else
            wake[i] <= 1'b1;
        @(posedge clk);
        irq_req <= 1'b0;
        wake <= 3'h0;
        tick(4);
        #2;
    endtask

    task automatic power_on();
        @(posedge clk);
        rst_b <= 1'b0;
        #2 check({jtag_rst, rsts}, 4'hF);
        tick(2);
        rst_b <= 1'b1;
        tick(4);
        #2 check(jtag_rst, 1'b0);
        seq(96);
        #2 check({mclk_en, cm_en, per_en}, 10'h3FF);
    endtask

    task automatic wait_mode();
        for (int i = 0; i < 3; i++)
        begin
            instr(1'b0);
            check({mclk_en, cm_en, per_en}, 10'h2FF);
            wake_ev(i);
            check({cm_en, per_en}, 9'h1FF);
        end
    endtask

    task automatic stop_mode();
        apb(1'b1, STOPDIS_OFF, 32'h1);
        apb(1'b0, STOPDIS_OFF, 32'h0);
        check(rd, 32'h1);
        for (int i = 1; i < 4; i++)
        begin
            instr(1'b1);
            check({mclk_en, cm_en, per_en}, 10'h201);
            wake_ev(i);
            check(cm_en, 1'b1);
        end
        apb(1'b1, STOPDIS_OFF, 32'h0);
        instr(1'b1);
        wake_ev(3);
        check({cm_en, per_en}, 9'h0);
    endtask

    // software, watchdog timeout, lost reference; first one leaves stop
    task automatic sync_resets();
        int n;
        for (int i = 0; i < 3; i++)
        begin
            if (i == 0)
                apb(1'b1, CTRL_OFF, 32'h1);
            @(posedge clk);
            wdog_to <= (i == 1);
            wdog_lor <= (i == 2);
            @(posedge clk);
            wdog_to <= 1'b0;
            wdog_lor <= 1'b0;
            tick(2);
            #2 check({jtag_rst, cg_rst, per_rst, core_rst, sw_rst}, 5'h0F);
            n = 0;
            fork
                while (sw_rst !== 1'b0)
                begin
                    @(posedge clk);
                    n += osc_tick;
                end
                seq(32);
            join
            near(n, 3);
            check(cm_en, 1'b1);
        end
    endtask

    task automatic standby();
        for (int i = 0; i < 4; i++)
            apb(1'b1, CLKCFG_OFF, 32'((2 << i) - 1));
        apb(1'b0, STATUS_OFF, 32'h0);
        check(rd[3:0], 4'h4);
        period(0, SYS_STBY_CYC);
        instr(1'b0);
        check({cm_en, per_en}, 9'h0FF);
        wake_ev(0);
        for (int i = 3; i >= 0; i--)
            apb(1'b1, CLKCFG_OFF, 32'((1 << i) - 1));
        period(0, SYS_RUN_CYC);
    endtask

    task automatic power_down();
        apb(1'b1, CLKCFG_OFF, 32'h0F);
        apb(1'b1, CLKCFG_OFF, 32'h1F);
        tick(2);
        #2 check({mclk_en, cm_en, per_en}, 10'h0);
        apb(1'b1, CTRL_OFF, 32'h1);
        @(posedge clk);
        wdog_lor <= 1'b1;
        @(posedge clk);
        wdog_lor <= 1'b0;
        tick(4);
        #2 check({cg_rst, mclk_en}, 2'b00);
        @(posedge clk);
        ext_rst_b <= 1'b0;
        #2 check({jtag_rst, rsts}, 4'h7);
        tick(2);
        ext_rst_b <= 1'b1;
        seq(32);
        #2 check(mclk_en, 1'b1);
    endtask

    task automatic misc();
        apb(1'b0, CLKCFG_OFF, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        period(1, OSC_CYC);
        period(2, OSC_CYC * 1024);
        apb(1'b1, CTRL_OFF, 32'h2);
        tick(2);
        #2 check(hs_en, 1'b1);
    endtask

    initial
    begin
        power_on();
        wait_mode();
        stop_mode();
        sync_resets();
        standby();
        power_down();
        misc();
        power_on();
        end_of_test();
    end
endmodule
`default_nettype wire
